// ---- hw/mlmd_core.sv ----
/*
  decode-and-execute for register copy, special-register moves, multiply,
  invert, inclusive or, the idle hint and the negate alias, with its own
  register file, status flags and an apb slave for control and inspection.
  assumes fetch is on clk_sys and presents one instruction per handshake.
*/
module mlmd_core
  import mlmd_pkg::*;
#(
  parameter bit HIGH_REGS_OK = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire logic [31:0]       instr_addr,
  input  wire logic [15:0]       instr_hw0,
  input  wire logic [15:0]       instr_hw1,
  output logic                   exec_done,
  output logic                   branch_valid,
  output logic      [31:0]       branch_target,
  output logic                   undef_seen,
  output logic                   foreign_op
);
  logic [1:0]  ctrl_ff;
  logic [3:0]  flags_ff;
  logic [2:0]  status_ff;
  logic [31:0] retired_ff;
  logic [3:0]  gpr_idx_ff;
  logic [1:0]  spec_ctl_ff;
  logic [31:0] gpr_ff [0:14];
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        done_ff;
  logic        branch_ff;
  logic [31:0] target_ff;
  logic        undef_ff;
  logic        foreign_ff;

  mlmd_op_t    op;
  logic [3:0]  dst;
  logic [3:0]  src;
  logic [7:0]  sel;
  logic        fire;
  logic        priv;
  logic [31:0] val_d;
  logic [31:0] val_s;
  logic [63:0] product;
  logic [32:0] neg_sum;
  logic        nxt_wr;
  logic [31:0] nxt_val;
  logic        nxt_fl_we;
  logic [3:0]  nxt_flags;
  logic        nxt_branch;
  logic [31:0] nxt_target;
  logic        nxt_ctl_we;
  logic        nxt_deny;
  logic        nxt_depr;
  logic        apb_wr;
  logic        apb_setup;
  logic        mapped;
  logic [31:0] nxt_prdata;

  mlmd_decode #(
    .HIGH_REGS_OK (HIGH_REGS_OK)
  ) u_decode (
    .hw0 (instr_hw0),
    .hw1 (instr_hw1),
    .op  (op),
    .dst (dst),
    .src (src),
    .sel (sel)
  );

  assign fire      = instr_valid && instr_ready;
  assign priv      = ctrl_ff[CTRL_PRIV_BIT];
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;

  // register reads, pc reads as the fetch address plus four
  function automatic logic [31:0] read_gpr(input logic [3:0] idx);
    read_gpr = (idx == IDX_PC) ? (instr_addr + PC_AHEAD) : gpr_ff[idx];
  endfunction

  assign val_d   = read_gpr(dst);
  assign val_s   = read_gpr(src);
  assign product = val_s * val_d;
  assign neg_sum = {1'b0, ~val_s} + 33'h1;

  always_comb begin
    nxt_wr     = 1'b0;
    nxt_val    = 32'h0;
    nxt_fl_we  = 1'b0;
    nxt_flags  = flags_ff;
    nxt_branch = 1'b0;
    nxt_target = 32'h0;
    nxt_ctl_we = 1'b0;
    nxt_deny   = 1'b0;
    nxt_depr   = 1'b0;
    case (op)
      MLMD_OP_COPY: begin
        nxt_depr = (dst >= IDX_SP) && (src >= IDX_SP);
        if (dst == IDX_PC) begin
          nxt_branch = 1'b1;
          nxt_target = {val_s[31:1], 1'b0};
        end else begin
          nxt_wr  = 1'b1;
          nxt_val = val_s;
        end
      end
      MLMD_OP_COPYS: begin
        nxt_wr    = 1'b1;
        nxt_val   = val_s;
        nxt_fl_we = 1'b1;
      end
      MLMD_OP_RDSPEC: begin
        nxt_wr = 1'b1;
        if (sel == SEL_FLAGS) begin
          nxt_val = {flags_ff, 28'h0};
        end else if (sel == SEL_CONTROL) begin
          nxt_val = {30'h0, spec_ctl_ff};
        end else if (priv && sel == SEL_STACK) begin
          nxt_val = gpr_ff[IDX_SP];
        end else begin
          nxt_deny = !priv;
        end
      end
      MLMD_OP_WRSPEC: begin
        if (sel == SEL_FLAGS) begin
          nxt_fl_we = 1'b1;
          nxt_flags = val_s[31:FLAGS_LSB];
        end else if (!priv) begin
          nxt_deny = 1'b1;
        end else begin
          nxt_ctl_we = (sel == SEL_CONTROL);
        end
      end
      MLMD_OP_MUL: begin
        nxt_wr    = 1'b1;
        nxt_val   = product[31:0];
        nxt_fl_we = 1'b1;
      end
      MLMD_OP_INV: begin
        nxt_wr    = 1'b1;
        nxt_val   = ~val_s;
        nxt_fl_we = 1'b1;
      end
      MLMD_OP_OR: begin
        nxt_wr    = 1'b1;
        nxt_val   = val_d | val_s;
        nxt_fl_we = 1'b1;
      end
      MLMD_OP_NEG: begin
        nxt_wr    = 1'b1;
        nxt_val   = neg_sum[31:0];
        nxt_fl_we = 1'b1;
        nxt_flags[FLAG_C] = neg_sum[32];
        nxt_flags[FLAG_V] = (val_s == 32'h80000000);
      end
      MLMD_OP_HINT: begin
        nxt_wr = 1'b0;
      end
      MLMD_OP_FOREIGN: begin
        nxt_wr = 1'b0;
      end
      MLMD_OP_UNDEF: begin
        nxt_wr = 1'b0;
      end
    endcase
    if (nxt_fl_we && op != MLMD_OP_WRSPEC) begin
      nxt_flags[FLAG_N] = nxt_val[31];
      nxt_flags[FLAG_Z] = (nxt_val == 32'h0);
    end
  end

  // register file, one flop word per entry
  for (genvar i = 0; i < 15; i++) begin : g_gpr
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        gpr_ff[i] <= 32'h0;
      end else if (fire && nxt_wr && dst == 4'(i)) begin
        gpr_ff[i] <= nxt_val;
      end else if (apb_wr && paddr == OFS_GPR_DATA && gpr_idx_ff == 4'(i)) begin
        gpr_ff[i] <= pwdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= FLAGS_RESET;
    end else if (fire && nxt_fl_we) begin
      flags_ff <= nxt_flags;
    end else if (apb_wr && paddr == OFS_FLAGS) begin
      flags_ff <= pwdata[31:FLAGS_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spec_ctl_ff <= 2'h0;
    end else if (fire && nxt_ctl_we) begin
      spec_ctl_ff <= val_s[1:0];
    end
  end

  // execution results toward fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_ff    <= 1'b0;
      branch_ff  <= 1'b0;
      target_ff  <= 32'h0;
      undef_ff   <= 1'b0;
      foreign_ff <= 1'b0;
    end else begin
      done_ff    <= fire;
      branch_ff  <= fire && nxt_branch;
      target_ff  <= (fire && nxt_branch) ? nxt_target : target_ff;
      undef_ff   <= fire && (op == MLMD_OP_UNDEF);
      foreign_ff <= fire && (op == MLMD_OP_FOREIGN);
    end
  end

  // sticky status, a set in the same cycle beats the write-one clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 3'h0;
    end else begin
      status_ff <= (status_ff & ~((apb_wr && paddr == OFS_STATUS) ? pwdata[2:0] : 3'h0))
                 | {fire && nxt_depr, fire && op == MLMD_OP_UNDEF, fire && nxt_deny};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      retired_ff <= 32'h0;
    end else if (fire) begin
      retired_ff <= retired_ff + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff    <= CTRL_RESET;
      gpr_idx_ff <= 4'h0;
    end else if (apb_wr && paddr == OFS_CTRL) begin
      ctrl_ff <= pwdata[1:0];
    end else if (apb_wr && paddr == OFS_GPR_IDX) begin
      gpr_idx_ff <= pwdata[3:0];
    end
  end

  // apb read data captured in the setup cycle
  always_comb begin
    mapped     = 1'b1;
    nxt_prdata = 32'h0;
    case (paddr)
      OFS_CTRL:     nxt_prdata = {30'h0, ctrl_ff};
      OFS_FLAGS:    nxt_prdata = {flags_ff, 28'h0};
      OFS_STATUS:   nxt_prdata = {29'h0, status_ff};
      OFS_RETIRED:  nxt_prdata = retired_ff;
      OFS_GPR_IDX:  nxt_prdata = {28'h0, gpr_idx_ff};
      OFS_GPR_DATA: nxt_prdata = (gpr_idx_ff == IDX_PC) ? 32'h0 : gpr_ff[gpr_idx_ff];
      default:      mapped     = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
      pready_ff  <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
      if (apb_setup) begin
        prdata_ff  <= pwrite ? 32'h0 : nxt_prdata;
        pslverr_ff <= !mapped;
      end
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign instr_ready   = ctrl_ff[CTRL_EN_BIT];
  assign exec_done     = done_ff;
  assign branch_valid  = branch_ff;
  assign branch_target = target_ff;
  assign undef_seen    = undef_ff;
  assign foreign_op    = foreign_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_fire(mlmd_op_t o);
    fire && op == o && !apb_wr;
  endsequence

  a_copy_flags_kept: assert property (s_fire(MLMD_OP_COPY) |=> $stable(flags_ff))
    else $error("plain copy changed flags");
  a_copy_pc_branch: assert property (s_fire(MLMD_OP_COPY) ##0 dst == IDX_PC
    |=> branch_valid && branch_target == {$past(val_s[31:1]), 1'b0})
    else $error("copy to pc did not branch");
  a_copys_zero_flag: assert property (s_fire(MLMD_OP_COPYS)
    |=> flags_ff[FLAG_Z] == ($past(val_s) == 32'h0) && gpr_ff[$past(dst)] == $past(val_s))
    else $error("flag copy result or zero flag wrong");
  a_mul_low_word: assert property (s_fire(MLMD_OP_MUL)
    |=> gpr_ff[$past(dst)] == $past(val_s) * $past(val_d))
    else $error("multiply low word wrong");
  a_mul_cv_kept: assert property (s_fire(MLMD_OP_MUL)
    |=> flags_ff[1:0] == $past(flags_ff[1:0]))
    else $error("multiply changed carry or overflow");
  a_inv_result: assert property (s_fire(MLMD_OP_INV)
    |=> gpr_ff[$past(dst)] == ~$past(val_s) && flags_ff[FLAG_C] == $past(flags_ff[FLAG_C]))
    else $error("invert result or carry wrong");
  a_or_result: assert property (s_fire(MLMD_OP_OR)
    |=> gpr_ff[$past(dst)] == ($past(val_d) | $past(val_s)))
    else $error("or result wrong");
  a_hint_no_effect: assert property (s_fire(MLMD_OP_HINT)
    |=> $stable(flags_ff) && !branch_valid && $stable(status_ff))
    else $error("idle hint had an effect");
  a_neg_carry: assert property (s_fire(MLMD_OP_NEG)
    |=> flags_ff[FLAG_C] == ($past(val_s) == 32'h0) && gpr_ff[$past(dst)] == -$past(val_s))
    else $error("negate result or carry wrong");
  a_spec_deny: assert property (fire && op == MLMD_OP_RDSPEC && !priv
    && sel != SEL_FLAGS && sel != SEL_CONTROL |=> status_ff[STAT_DENY_BIT])
    else $error("unprivileged special read not flagged");
endmodule // mlmd_core

// ---- hw/mlmd_decode.sv ----
/*
  combinational decoder for the move / logic / multiply group.
  assumes the halfwords come straight from the fetch stage, hw0 first.
*/
module mlmd_decode
  import mlmd_pkg::*;
#(
  parameter bit HIGH_REGS_OK = 1'b1
) (
  input  wire logic [15:0] hw0,
  input  wire logic [15:0] hw1,
  output mlmd_op_t         op,
  output logic      [3:0]  dst,
  output logic      [3:0]  src,
  output logic      [7:0]  sel
);
  logic is_wide;

  assign is_wide = (hw0[15:13] == 3'h7) && (hw0[12:11] != 2'h0);

  always_comb begin
    op  = MLMD_OP_FOREIGN;
    dst = {1'b0, hw0[2:0]};
    src = {1'b0, hw0[5:3]};
    sel = hw1[7:0];
    if (is_wide) begin
      if (hw0 == ENC_RDSPEC_HW0 && hw1[15:12] == ENC_RDSPEC_HW1) begin
        op  = MLMD_OP_RDSPEC;
        dst = hw1[11:8];
      end else if (hw0[15:4] == ENC_WRSPEC_HW0 && hw1[15:8] == ENC_WRSPEC_HW1) begin
        op  = MLMD_OP_WRSPEC;
        src = hw0[3:0];
      end
    end else if (hw0[15:8] == ENC_COPY_HI) begin
      dst = {hw0[7], hw0[2:0]};
      src = hw0[6:3];
      op  = MLMD_OP_COPY;
      if (!HIGH_REGS_OK && (dst[3] || src[3])) begin
        op = MLMD_OP_UNDEF;
      end
    end else if (hw0[15:6] == ENC_COPY_FL) begin
      op = MLMD_OP_COPYS;
    end else if (hw0[15:11] == ENC_SHIFT_IMM) begin
      op = MLMD_OP_FOREIGN;
    end else if (hw0[15:6] == ENC_MUL) begin
      op = MLMD_OP_MUL;
    end else if (hw0[15:6] == ENC_INV) begin
      op = MLMD_OP_INV;
    end else if (hw0[15:6] == ENC_OR) begin
      op = MLMD_OP_OR;
    end else if (hw0[15:6] == ENC_NEGATE) begin
      op = MLMD_OP_NEG;
    end else if (hw0 == ENC_HINT) begin
      op = MLMD_OP_HINT;
    end
  end
endmodule // mlmd_decode

// ---- hw/mlmd_pkg.sv ----
/*
  constants for the move / logic / multiply decode-and-execute block:
  apb register map, field positions, encodings, special selectors.
  assumes a single 250 MHz clock domain and a 32-bit apb master.
*/
package mlmd_pkg;
  localparam int          APB_AW         = 8;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_FLAGS      = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_RETIRED    = 8'h0c;
  localparam logic [7:0]  OFS_GPR_IDX    = 8'h10;
  localparam logic [7:0]  OFS_GPR_DATA   = 8'h14;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_PRIV_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int          FLAGS_LSB      = 28;
  localparam logic [3:0]  FLAGS_RESET    = 4'h0;
  localparam int          FLAG_N         = 3;
  localparam int          FLAG_Z         = 2;
  localparam int          FLAG_C         = 1;
  localparam int          FLAG_V         = 0;
  localparam int          STAT_DENY_BIT  = 0;
  localparam int          STAT_UNDEF_BIT = 1;
  localparam int          STAT_DEPR_BIT  = 2;
  localparam logic [7:0]  SEL_FLAGS      = 8'h00;
  localparam logic [7:0]  SEL_STACK      = 8'h08;
  localparam logic [7:0]  SEL_CONTROL    = 8'h14;
  localparam logic [3:0]  IDX_SP         = 4'hd;
  localparam logic [3:0]  IDX_PC         = 4'hf;
  localparam logic [31:0] PC_AHEAD       = 32'h4;
  localparam logic [7:0]  ENC_COPY_HI    = 8'h46;
  localparam logic [9:0]  ENC_COPY_FL    = 10'h000;
  localparam logic [4:0]  ENC_SHIFT_IMM  = 5'h00;
  localparam logic [9:0]  ENC_NEGATE     = 10'h109;
  localparam logic [9:0]  ENC_OR         = 10'h10c;
  localparam logic [9:0]  ENC_MUL        = 10'h10d;
  localparam logic [9:0]  ENC_INV        = 10'h10f;
  localparam logic [15:0] ENC_HINT       = 16'hbf00;
  localparam logic [15:0] ENC_RDSPEC_HW0 = 16'hf3ef;
  localparam logic [3:0]  ENC_RDSPEC_HW1 = 4'h8;
  localparam logic [11:0] ENC_WRSPEC_HW0 = 12'hf38;
  localparam logic [7:0]  ENC_WRSPEC_HW1 = 8'h88;

  typedef enum logic [3:0] {
    MLMD_OP_COPY   = 4'h0,
    MLMD_OP_COPYS  = 4'h1,
    MLMD_OP_RDSPEC = 4'h2,
    MLMD_OP_WRSPEC = 4'h3,
    MLMD_OP_MUL    = 4'h4,
    MLMD_OP_INV    = 4'h5,
    MLMD_OP_OR     = 4'h6,
    MLMD_OP_HINT   = 4'h7,
    MLMD_OP_NEG    = 4'h8,
    MLMD_OP_FOREIGN = 4'h9,
    MLMD_OP_UNDEF  = 4'ha
  } mlmd_op_t;
endpackage

// ---- verif/mlmd_fetch_model.sv ----
/*
  fetch-stage model: offers one instruction at a time on valid/ready.
  assumes clk_sys from the bench and calls that start right after an edge.
*/
module mlmd_fetch_model (
  input  wire logic        clk_sys,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic      [31:0] instr_addr,
  output logic      [15:0] instr_hw0,
  output logic      [15:0] instr_hw1
);
  timeunit 1ns;
  timeprecision 1ps;
  bit held = 1'b0;
  initial begin
    instr_valid = 1'b0;
    instr_addr  = 32'h0;
    instr_hw0   = 16'h0;
    instr_hw1   = 16'h0;
  end
  // kp keeps valid up for a back-to-back offer
  task automatic offer(input logic [15:0] h0, h1, input logic [31:0] a,
                       input int gap, input bit kp, output bit ok);
    if (!held) begin
      repeat (gap + 1) @(posedge clk_sys);
    end
    instr_valid <= 1'b1;
    instr_addr  <= a;
    instr_hw0   <= h0;
    instr_hw1   <= h1;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk_sys);
      ok = (instr_ready === 1'b1);
    end
    held = kp;
    // released lines show the inverse, never a stale value
    if (!kp) begin
      instr_valid <= 1'b0;
      instr_addr  <= ~a;
      instr_hw0   <= ~h0;
      instr_hw1   <= ~h1;
    end
  endtask
endmodule // mlmd_fetch_model

// ---- verif/tb_top.sv ----
/*
  bench for mlmd_core: apb master, fetch model, reference registers and
  flags; expectations queued and checked by output monitors.
  assumes the designer's register map and a one-cycle instruction answer.
*/
module tb_top
  import mlmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RST_OFS [4] = '{OFS_CTRL, OFS_FLAGS, OFS_STATUS, OFS_RETIRED};
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, instr_addr, branch_target, tgt, iaddr;
  logic        instr_valid, instr_ready, exec_done, branch_valid, undef_seen, foreign_op;
  logic [15:0] instr_hw0, instr_hw1;
  logic [31:0] gpr [16];
  logic [3:0]  fl;
  logic [32:0] rdq [$];
  logic [34:0] exq [$];
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 32'h6e1d0a72;

  mlmd_core #(.HIGH_REGS_OK(1'b1)) i_mlmd_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_addr(instr_addr), .instr_hw0(instr_hw0), .instr_hw1(instr_hw1),
    .exec_done(exec_done), .branch_valid(branch_valid), .branch_target(branch_target),
    .undef_seen(undef_seen), .foreign_op(foreign_op));
  mlmd_fetch_model i_mlmd_fetch_model (
    .clk_sys(clk_sys), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_addr(instr_addr), .instr_hw0(instr_hw0), .instr_hw1(instr_hw1));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [32:0] e, a);
    total_checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected read at %0t: exp %h got %h", $time, e, a);
    end
  endtask

  task automatic cmp_ex(input logic [34:0] e, a);
    total_checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected result at %0t: exp %h got %h", $time, e, a);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic apb_rd(input logic [7:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic rd_gpr(input logic [3:0] i);
    apb_wr(OFS_GPR_IDX, {28'h0, i});
    apb_rd(OFS_GPR_DATA, {1'b0, (i == IDX_PC) ? 32'h0 : gpr[i]});
  endtask

  task automatic issue(input logic [15:0] h0, h1, input logic bv, fo,
                       input logic [31:0] t, input bit kp);
    bit ok;
    if (bv) begin
      tgt = t & 32'hfffffffe;
    end
    exq.push_back({bv, 1'b0, fo, tgt});
    i_mlmd_fetch_model.offer(h0, h1, iaddr, {$random(seed)} % 4, kp, ok);
    if (!ok) begin
      failures++;
      print_verdict();
    end
  endtask

  // a pulse with no note queued compares against unknown and fails
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp_rd(rdq.size() ? rdq.pop_front() : 33'bx, {pslverr, prdata});
    end
    if ({exec_done, branch_valid, undef_seen, foreign_op} !== 4'h0) begin
      cmp_ex((exec_done === 1'b1 && exq.size()) ? exq.pop_front() : 35'bx,
             {branch_valid, undef_seen, foreign_op, branch_target});
    end
  end

  initial begin
    logic [31:0] v, r, s;
    logic [15:0] h0;
    logic [3:0]  d, m;
    int          k;
    bit          kp;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fl = 4'h0;
    tgt = 32'h0;
    iaddr = 32'h100;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (RST_OFS[i]) apb_rd(RST_OFS[i], 33'h0);
    apb_rd(8'h40, {1'b1, 32'h0});
    // held while disabled, taken only after enable
    fork
      i_mlmd_fetch_model.offer(ENC_HINT, 16'h0, iaddr, 0, 1'b0, kp);
      begin
        repeat (8) @(posedge clk_sys);
        exq.push_back({3'b000, tgt});
        apb_wr(OFS_CTRL, 32'h1);
      end
    join
    if (!kp) begin
      failures++;
      print_verdict();
    end
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      gpr[i] = (i == 15) ? 32'h0 : v;
      apb_wr(OFS_GPR_IDX, 32'(i));
      apb_wr(OFS_GPR_DATA, v);
    end
    for (int i = 0; i < 150; i++) begin
      k = {$random(seed)} % 8;
      d = 4'($random(seed));
      m = 4'($random(seed));
      v = $random(seed);
      iaddr = $random(seed) & 32'hfffffffe;
      kp = (i < 149) && ({$random(seed)} % 2 == 1);
      if (k != 0) begin
        d[3] = 1'b0;
        m[3] = 1'b0;
      end
      if (k == 0 && d >= IDX_SP && m >= IDX_SP) m[3] = 1'b0;
      s = (m == IDX_PC) ? iaddr + PC_AHEAD : gpr[m];
      case (k)
        0: h0 = {ENC_COPY_HI, d[3], m, d[2:0]};
        1: h0 = {ENC_COPY_FL, m[2:0], d[2:0]};
        2: h0 = {ENC_MUL, m[2:0], d[2:0]};
        3: h0 = {ENC_INV, m[2:0], d[2:0]};
        4: h0 = {ENC_OR, m[2:0], d[2:0]};
        5: h0 = {ENC_NEGATE, m[2:0], d[2:0]};
        6: h0 = ENC_HINT;
        default: h0 = {5'h00, 1'b1, m, d[2:0], d[2:0]};
      endcase
      case (k)
        0, 1: r = s;
        2: r = s * gpr[d];
        3: r = ~s;
        4: r = s | gpr[d];
        5: r = 32'h0 - s;
        default: r = gpr[d];
      endcase
      issue(h0, v[15:0], k == 0 && d == IDX_PC, k == 7, s, kp);
      if (!(k == 0 && d == IDX_PC)) gpr[d] = r;
      if (k >= 1 && k <= 5) fl[3:2] = {r[31], r == 32'h0};
      if (k == 5) fl[1:0] = {s == 32'h0, s == 32'h80000000};
      if (!kp) begin
        apb_rd(OFS_FLAGS, {1'b0, fl, 28'h0});
        rd_gpr(d);
      end
    end
    issue(ENC_RDSPEC_HW0, {ENC_RDSPEC_HW1, 4'h2, SEL_FLAGS}, 1'b0, 1'b0, 32'h0, 1'b0);
    gpr[2] = {fl, 28'h0};
    rd_gpr(4'h2);
    issue(ENC_RDSPEC_HW0, {ENC_RDSPEC_HW1, 4'h3, SEL_STACK}, 1'b0, 1'b0, 32'h0, 1'b0);
    gpr[3] = 32'h0;
    rd_gpr(4'h3);
    apb_rd(OFS_STATUS, 33'h1);
    apb_wr(OFS_STATUS, 32'h1);
    issue({ENC_WRSPEC_HW0, 4'h4}, {ENC_WRSPEC_HW1, SEL_FLAGS}, 1'b0, 1'b0, 32'h0, 1'b0);
    fl = gpr[4][31:28];
    apb_rd(OFS_FLAGS, {1'b0, fl, 28'h0});
    apb_rd(OFS_STATUS, 33'h0);
    issue({ENC_WRSPEC_HW0, 4'h6}, {ENC_WRSPEC_HW1, SEL_STACK}, 1'b0, 1'b0, 32'h0, 1'b0);
    apb_rd(OFS_STATUS, 33'h1);
    rd_gpr(IDX_SP);
    apb_wr(OFS_CTRL, 32'h3);
    issue(ENC_RDSPEC_HW0, {ENC_RDSPEC_HW1, 4'h5, SEL_STACK}, 1'b0, 1'b0, 32'h0, 1'b0);
    gpr[5] = gpr[13];
    rd_gpr(4'h5);
    issue({ENC_WRSPEC_HW0, 4'h7}, {ENC_WRSPEC_HW1, SEL_CONTROL}, 1'b0, 1'b0, 32'h0, 1'b0);
    issue(ENC_RDSPEC_HW0, {ENC_RDSPEC_HW1, 4'h2, SEL_CONTROL}, 1'b0, 1'b0, 32'h0, 1'b0);
    gpr[2] = {30'h0, gpr[7][1:0]};
    rd_gpr(4'h2);
    // directed copy of r1 into pc, the random loop may miss it
    issue({ENC_COPY_HI, 1'b1, 4'h1, 3'h7}, 16'h0, 1'b1, 1'b0, gpr[1], 1'b0);
    rd_gpr(IDX_PC);
    apb_rd(OFS_RETIRED, {1'b0, 32'h9f});
    repeat (4) @(posedge clk_sys);
    if (exq.size() != 0 || rdq.size() != 0) failures++;
    print_verdict();
  end
endmodule // tb_top
